// >>> verilog/tss_pkg.sv
// constants for the timestamp synchronisation selector
package tss_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_HOST_SEC = 8'h04;
  localparam logic [7:0] REG_HOST_NS  = 8'h08;
  localparam logic [7:0] REG_THRESH   = 8'h0c;
  localparam logic [7:0] REG_TS_SEC   = 8'h10;
  localparam logic [7:0] REG_TS_NS    = 8'h14;
  localparam logic [7:0] REG_STATUS   = 8'h18;
  localparam logic [7:0] REG_TOTAL    = 8'h1c;
  localparam logic [7:0] REG_BAD      = 8'h20;
  localparam logic [7:0] REG_MISSED   = 8'h24;
  localparam logic [7:0] REG_PHASE    = 8'h28;

  // ----------------------------------------------------------------
  // control fields and command bits
  // ----------------------------------------------------------------
  localparam int CTRL_IN_LSB    = 0;
  localparam int CTRL_OUT_LSB   = 2;
  localparam int CMD_SET_BIT    = 8;
  localparam int CMD_RESET_BIT  = 9;
  localparam int CMD_HOST_BIT   = 10;
  localparam int CMD_CLEAR_BIT  = 11;

  // input and output selector encodings
  typedef enum logic [1:0] {
    TSS_IN_NONE = 2'h0,
    TSS_IN_DIFF = 2'h1,
    TSS_IN_HOST = 2'h2
  } tss_in_sel_t;

  typedef enum logic [1:0] {
    TSS_OUT_NONE   = 2'h0,
    TSS_OUT_PASS   = 2'h1,
    TSS_OUT_LOOP   = 2'h2,
    TSS_OUT_MASTER = 2'h3
  } tss_out_sel_t;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam tss_in_sel_t  IN_SEL_RST  = TSS_IN_DIFF;
  localparam tss_out_sel_t OUT_SEL_RST = TSS_OUT_NONE;
  localparam logic [31:0]  THRESH_RST_NS = 32'd596;
  localparam int           CLK_MHZ     = 125;
  localparam logic [31:0]  TICK_NS     = 32'(1000 / CLK_MHZ);
  localparam logic [31:0]  NS_PER_SEC  = 32'd1000000000;
  localparam logic [31:0]  HALF_SEC_NS = 32'd500000000;
  localparam logic [31:0]  MASTER_PULSE_NS = 32'd100000000;
  localparam int           MISS_MS     = 1500;
  localparam int           MISS_CYC    = MISS_MS * 1000 * CLK_MHZ;

endpackage

// >>> verilog/tss_top.sv
// timestamp clock with selectable second-pulse discipline and sync output
// ------------------------------------------------------------------
// ------------------------------------------------------------------
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module tss_top #(
  parameter int MISS_CYC = tss_pkg::MISS_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output wire logic        s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output wire logic        s_axi_wready_o,
  output logic      [1:0]  s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output wire logic        s_axi_arready_o,
  output logic      [31:0] s_axi_rdata_o,
  output logic      [1:0]  s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // sync port circuit A
  input  wire logic        sync_in_a_p_i,
  input  wire logic        sync_in_a_n_i,
  output logic             sync_out_a_p_o,
  output logic             sync_out_a_n_o,
  output logic             sync_out_a_oe_o,
  // status
  output wire logic        synced_o
);

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  tss_pkg::tss_in_sel_t  in_sel;
  tss_pkg::tss_out_sel_t out_sel;
  logic [31:0] host_sec;
  logic [31:0] host_ns;
  logic [31:0] thresh;
  logic [31:0] ts_sec;
  logic [31:0] ts_ns;
  logic [31:0] cnt_total;
  logic [31:0] cnt_bad;
  logic [31:0] cnt_missed;
  logic [31:0] phase_err;
  logic        synced;
  logic [31:0] miss_cnt;
  logic [2:0]  sync_p;
  logic [2:0]  sync_n;
  logic        lvl_p;
  logic        lvl_n;
  logic        diff_lvl_q;
  logic        sel_lvl_q;
  logic        host_tick;
  logic        aw_full;
  logic        w_full;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // ----------------------------------------------------------------
  // pin synchronisers and filter
  // ----------------------------------------------------------------
  // three stages; a level changes only once stages two and three agree
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_p <= 3'h0;
      sync_n <= 3'h7;
      lvl_p  <= 1'b0;
      lvl_n  <= 1'b1;
    end else begin
      sync_p <= {sync_p[1:0], sync_in_a_p_i};
      sync_n <= {sync_n[1:0], sync_in_a_n_i};
      if (sync_p[1] == sync_p[2]) begin
        lvl_p <= sync_p[2];
      end
      if (sync_n[1] == sync_n[2]) begin
        lvl_n <= sync_n[2];
      end
    end
  end

  wire diff_lvl  = lvl_p & ~lvl_n;
  wire diff_rise = diff_lvl & ~diff_lvl_q;

  // ----------------------------------------------------------------
  // input selection
  // ----------------------------------------------------------------
  // choose the disciplining source
  wire sel_lvl = (in_sel == tss_pkg::TSS_IN_DIFF) ? diff_lvl :
                 (in_sel == tss_pkg::TSS_IN_HOST) ? host_tick : 1'b0;
  // host tick acts as the second mark
  wire sel_evt = (in_sel == tss_pkg::TSS_IN_DIFF) ? diff_rise :
                 (in_sel == tss_pkg::TSS_IN_HOST) ? host_tick : 1'b0;

  // phase error: ns past the second, or negative when just before it
  wire        late      = ts_ns < tss_pkg::HALF_SEC_NS;
  wire [31:0] err       = late ? ts_ns : ts_ns - tss_pkg::NS_PER_SEC;
  wire [31:0] err_abs   = late ? ts_ns : tss_pkg::NS_PER_SEC - ts_ns;
  wire        err_ok    = err_abs <= thresh;
  // a reserved selector code counts as no source at all
  wire        src_on    = (in_sel == tss_pkg::TSS_IN_DIFF) || (in_sel == tss_pkg::TSS_IN_HOST);
  wire        miss_hit  = src_on && (miss_cnt >= 32'(MISS_CYC - 1));

  // ----------------------------------------------------------------
  // bus write decode
  // ----------------------------------------------------------------
  wire do_wr    = aw_full & w_full & ~s_axi_bvalid_o;
  wire wr_ctrl  = do_wr && (aw_addr == tss_pkg::REG_CTRL);
  wire cmd_set  = wr_ctrl & w_strb[1] & w_data[tss_pkg::CMD_SET_BIT];
  wire cmd_rst  = wr_ctrl & w_strb[1] & w_data[tss_pkg::CMD_RESET_BIT];
  wire cmd_host = wr_ctrl & w_strb[1] & w_data[tss_pkg::CMD_HOST_BIT];
  wire cmd_clr  = wr_ctrl & w_strb[1] & w_data[tss_pkg::CMD_CLEAR_BIT];
  wire wr_known = (aw_addr == tss_pkg::REG_CTRL) || (aw_addr == tss_pkg::REG_HOST_SEC) ||
                  (aw_addr == tss_pkg::REG_HOST_NS) || (aw_addr == tss_pkg::REG_THRESH);
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // reset defaults: differential in, no out
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_sel    <= tss_pkg::IN_SEL_RST;
      out_sel   <= tss_pkg::OUT_SEL_RST;
      host_sec  <= 32'h0;
      host_ns   <= 32'h0;
      thresh    <= tss_pkg::THRESH_RST_NS;
      host_tick <= 1'b0;
    end else begin
      host_tick <= cmd_host;
      if (cmd_rst) begin
        in_sel  <= tss_pkg::IN_SEL_RST;
        out_sel <= tss_pkg::OUT_SEL_RST;
      end else if (wr_ctrl && w_strb[0]) begin
        in_sel  <= tss_pkg::tss_in_sel_t'(w_data[tss_pkg::CTRL_IN_LSB +: 2]);
        out_sel <= tss_pkg::tss_out_sel_t'(w_data[tss_pkg::CTRL_OUT_LSB +: 2]);
      end
      if (do_wr && aw_addr == tss_pkg::REG_HOST_SEC) begin
        host_sec <= merge(host_sec, w_data, wmask);
      end
      if (do_wr && aw_addr == tss_pkg::REG_HOST_NS) begin
        host_ns <= merge(host_ns, w_data, wmask);
      end
      if (do_wr && aw_addr == tss_pkg::REG_THRESH) begin
        thresh <= merge(thresh, w_data, wmask);
      end
    end
  end

  // ----------------------------------------------------------------
  // timestamp clock
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ts_sec <= 32'h0;
      ts_ns  <= 32'h0;
    end else if (cmd_set || cmd_rst) begin
      ts_sec <= host_sec;
      ts_ns  <= host_ns;
    end else if (sel_evt) begin
      // snap to the nearest second on every mark
      ts_ns  <= 32'h0;
      ts_sec <= late ? ts_sec : ts_sec + 32'h1;
    end else if (ts_ns + tss_pkg::TICK_NS >= tss_pkg::NS_PER_SEC) begin
      // free run from the local oscillator
      ts_ns  <= ts_ns + tss_pkg::TICK_NS - tss_pkg::NS_PER_SEC;
      ts_sec <= ts_sec + 32'h1;
    end else begin
      ts_ns  <= ts_ns + tss_pkg::TICK_NS;
    end
  end

  // ----------------------------------------------------------------
  // pulse statistics and health
  // ----------------------------------------------------------------
  // a mark in the clearing cycle is still counted
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_total  <= 32'h0;
      cnt_bad    <= 32'h0;
      cnt_missed <= 32'h0;
      phase_err  <= 32'h0;
      synced     <= 1'b0;
      miss_cnt   <= 32'h0;
    end else begin
      miss_cnt <= (sel_evt || miss_hit || !src_on) ? 32'h0 : miss_cnt + 32'h1;
      if (sel_evt) begin
        cnt_total <= cmd_clr ? 32'h1 : cnt_total + 32'h1;
        phase_err <= err;
        synced    <= err_ok;
      end else if (cmd_clr) begin
        cnt_total <= 32'h0;
      end
      if (sel_evt && !err_ok) begin
        cnt_bad <= cmd_clr ? 32'h1 : cnt_bad + 32'h1;
      end else if (cmd_clr) begin
        cnt_bad <= 32'h0;
      end
      if (miss_hit) begin
        cnt_missed <= cmd_clr ? 32'h1 : cnt_missed + 32'h1;
        synced     <= 1'b0;
      end else if (cmd_clr) begin
        cnt_missed <= 32'h0;
      end
      // setting time or dropping the source loses lock
      if (cmd_set || cmd_rst || !src_on) begin
        synced <= 1'b0;
      end
    end
  end

  assign synced_o = synced;

  // ----------------------------------------------------------------
  // sync output
  // ----------------------------------------------------------------
  // master pulse from the card's own second
  wire master_lvl = ts_ns < tss_pkg::MASTER_PULSE_NS;
  wire out_lvl = (out_sel == tss_pkg::TSS_OUT_PASS)   ? diff_lvl :
                 (out_sel == tss_pkg::TSS_OUT_LOOP)   ? sel_lvl :
                 (out_sel == tss_pkg::TSS_OUT_MASTER) ? master_lvl : 1'b0;

  // driven on outgoing circuit A; released when none
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      diff_lvl_q      <= 1'b0;
      sel_lvl_q       <= 1'b0;
      sync_out_a_p_o  <= 1'b0;
      sync_out_a_n_o  <= 1'b1;
      sync_out_a_oe_o <= 1'b0;
    end else begin
      diff_lvl_q      <= diff_lvl;
      sel_lvl_q       <= sel_lvl;
      sync_out_a_p_o  <= out_lvl;
      sync_out_a_n_o  <= ~out_lvl;
      // no drive when the output is off
      sync_out_a_oe_o <= (out_sel != tss_pkg::TSS_OUT_NONE);
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data are taken independently, in either order
  assign s_axi_awready_o = ~aw_full;
  assign s_axi_wready_o  = ~w_full;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_full        <= 1'b0;
      w_full         <= 1'b0;
      aw_addr        <= 8'h0;
      w_data         <= 32'h0;
      w_strb         <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= 2'h0;
    end else begin
      if (s_axi_awvalid_i && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= {s_axi_awaddr_i[7:2], 2'h0};
      end
      if (s_axi_wvalid_i && !w_full) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (do_wr) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_known ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        aw_full        <= 1'b0;
        w_full         <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  wire [7:0] ra = {s_axi_araddr_i[7:2], 2'h0};
  wire [31:0] status_word = {31'h0, synced};
  wire [31:0] ctrl_word   = {28'h0, out_sel, in_sel};
  wire rd_known = (ra <= tss_pkg::REG_PHASE);
  wire [31:0] rd_mux =
      (ra == tss_pkg::REG_CTRL)     ? ctrl_word  :
      (ra == tss_pkg::REG_HOST_SEC) ? host_sec   :
      (ra == tss_pkg::REG_HOST_NS)  ? host_ns    :
      (ra == tss_pkg::REG_THRESH)   ? thresh     :
      (ra == tss_pkg::REG_TS_SEC)   ? ts_sec     :
      (ra == tss_pkg::REG_TS_NS)    ? ts_ns      :
      (ra == tss_pkg::REG_STATUS)   ? status_word :
      (ra == tss_pkg::REG_TOTAL)    ? cnt_total  :
      (ra == tss_pkg::REG_BAD)      ? cnt_bad    :
      (ra == tss_pkg::REG_MISSED)   ? cnt_missed :
      (ra == tss_pkg::REG_PHASE)    ? phase_err  : 32'h0;

  assign s_axi_arready_o = ~s_axi_rvalid_o;

  // one read at a time; arready drops while the answer waits
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0;
      s_axi_rresp_o  <= 2'h0;
    end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= rd_known ? rd_mux : 32'h0;
      s_axi_rresp_o  <= rd_known ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

endmodule

// >>> bench/tss_top_props.sv
// port checker for the timestamp synchronisation selector
`timescale 1ns/1ps

module tss_top_props #(
  parameter int MISS_CYC = tss_pkg::MISS_CYC
) (
  input wire logic        clk_sys_i,
  input wire logic        resetn_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [7:0]  s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        sync_out_a_p_o,
  input wire logic        sync_out_a_n_o,
  input wire logic        sync_out_a_oe_o
);
  // ----------------------------------------------------------------
  // properties, all in the system clock domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  chk_pair_inverse:
    assert property (sync_out_a_oe_o |-> sync_out_a_n_o == !sync_out_a_p_o)
    else $error("outgoing pair legs not complementary");
  chk_rd_latency:
    assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  chk_rd_unmapped:
    assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[7:2] > 6'h0a
      |=> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0)
    else $error("unmapped read not refused");
  chk_rd_once:
    assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read answer repeated");
  chk_ar_blocked:
    assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("address taken while answer pending");
  chk_wr_answer:
    assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
      && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
    else $error("write answer late");
  chk_wr_blocked:
    assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while answer pending");
  chk_b_once:
    assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write answer repeated");
endmodule

bind tss_top tss_top_props #(.MISS_CYC(MISS_CYC)) u_props (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .sync_out_a_p_o(sync_out_a_p_o), .sync_out_a_n_o(sync_out_a_n_o),
  .sync_out_a_oe_o(sync_out_a_oe_o));

// >>> bench/tss_pulse_src.sv
// second-pulse source standing in for an external time receiver
`timescale 1ns/1ps

module tss_pulse_src #(
  parameter int WIDTH = 12
) (
  input  wire logic clk_i,
  input  wire logic fire_i,
  output logic      p_o,
  output logic      n_o
);
  int cnt = 0;

  // one mark per request, width cycles long
  always @(posedge clk_i) begin
    if (fire_i)
      cnt <= WIDTH;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end

  // differential legs, idle low on the positive leg
  assign p_o = (cnt > 0);
  assign n_o = ~p_o;
endmodule

// >>> bench/test_tss_top.sv
// self-checking bench for the timestamp synchronisation selector
`timescale 1ns/1ps

module test_tss_top;
  logic        clk_sys_i = 1'b0;
  logic        resetn_i  = 1'b0;
  logic [7:0]  awaddr    = 8'h00;
  logic [7:0]  araddr    = 8'h00;
  logic [31:0] wdata     = 32'h0;
  logic        awvalid   = 1'b0;
  logic        wvalid    = 1'b0;
  logic        arvalid   = 1'b0;
  logic        fire      = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire         in_p, in_n, out_p, out_n, out_oe, synced;
  int          errors      = 0;
  int          check_count = 0;
  logic [31:0] d;
  logic [1:0]  r;
  logic        s;

  always #4 clk_sys_i = ~clk_sys_i;

  // short miss window keeps the run brief
  tss_top #(.MISS_CYC(2000)) dut_u (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(1'b1), .sync_in_a_p_i(in_p), .sync_in_a_n_i(in_n),
    .sync_out_a_p_o(out_p), .sync_out_a_n_o(out_n), .sync_out_a_oe_o(out_oe),
    .synced_o(synced));

  tss_pulse_src pulse_u (.clk_i(clk_sys_i), .fire_i(fire), .p_o(in_p), .n_o(in_n));

  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  // handshakes judged just before the edge, ready depends on registers only
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic aw;
    logic w;
    logic b;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk_sys_i);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      r = bresp;
      @(posedge clk_sys_i);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
    end
    chk32({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar;
    logic rv;
    araddr <= a;
    arvalid <= 1'b1;
    rv = 1'b0;
    while (!rv) begin
      @(negedge clk_sys_i);
      ar = arvalid & arready;
      rv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_sys_i);
      if (ar)
        arvalid <= 1'b0;
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk32(d, e);
    chk32({30'h0, r}, 32'h0);
  endtask

  // one mark from the source, noting whether the sync output went high
  task automatic pulse();
    fire <= 1'b1;
    @(posedge clk_sys_i);
    fire <= 1'b0;
    s = 1'b0;
    repeat (20) begin
      @(negedge clk_sys_i);
      s = s | out_p;
    end
    @(posedge clk_sys_i);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_chk(tss_pkg::REG_CTRL, 32'h1);
    chk1(out_oe, 1'b0);
    rd_chk(tss_pkg::REG_THRESH, 32'd596);
    rd(8'h2c);
    chk32({r, d[29:0]}, 32'h80000000);
    wr(tss_pkg::REG_TS_SEC, 32'h9, 2'h2);
    wr(tss_pkg::REG_HOST_SEC, 32'd5, 2'h0);
    wr(tss_pkg::REG_HOST_NS, 32'h0, 2'h0);
    wr(tss_pkg::REG_CTRL, 32'h101, 2'h0);
    rd_chk(tss_pkg::REG_CTRL, 32'h1);
    rd_chk(tss_pkg::REG_TS_SEC, 32'd5);
    repeat (200) @(posedge clk_sys_i);
    rd(tss_pkg::REG_TS_NS);
    chk1(d >= 32'd1600, 1'b1);
    pulse();
    chk1(s, 1'b0);
    rd(tss_pkg::REG_TS_NS);
    chk1(d < 32'd400, 1'b1);
    rd_chk(tss_pkg::REG_TS_SEC, 32'd5);
    rd_chk(tss_pkg::REG_TOTAL, 32'd1);
    wr(tss_pkg::REG_CTRL, 32'h005, 2'h0);
    // enable is launched by the edge the write ends on
    @(negedge clk_sys_i);
    chk1(out_oe, 1'b1);
    @(posedge clk_sys_i);
    pulse();
    chk1(s, 1'b1);
    wr(tss_pkg::REG_CTRL, 32'h009, 2'h0);
    pulse();
    chk1(s, 1'b1);
    // two marks close to the second: locked, only the first was bad
    rd_chk(tss_pkg::REG_STATUS, 32'h1);
    chk1(synced, 1'b1);
    rd_chk(tss_pkg::REG_BAD, 32'h1);
    wr(tss_pkg::REG_CTRL, 32'h008, 2'h0);
    pulse();
    chk1(s, 1'b0);
    rd_chk(tss_pkg::REG_TOTAL, 32'd3);
    // master pulse ends 80 ns after the loaded time
    wr(tss_pkg::REG_HOST_NS, 32'd99999920, 2'h0);
    wr(tss_pkg::REG_CTRL, 32'h10d, 2'h0);
    @(negedge clk_sys_i);
    chk1(out_p, 1'b1);
    chk1(out_n, 1'b0);
    repeat (20) @(posedge clk_sys_i);
    chk1(out_p, 1'b0);
    wr(tss_pkg::REG_HOST_NS, 32'h0, 2'h0);
    wr(tss_pkg::REG_CTRL, 32'h102, 2'h0);
    repeat (200) @(posedge clk_sys_i);
    wr(tss_pkg::REG_CTRL, 32'h402, 2'h0);
    rd(tss_pkg::REG_TS_NS);
    chk1(d < 32'd400, 1'b1);
    rd_chk(tss_pkg::REG_TOTAL, 32'd4);
    // a second tick a few cycles later lands inside the threshold
    wr(tss_pkg::REG_CTRL, 32'h402, 2'h0);
    rd_chk(tss_pkg::REG_STATUS, 32'h1);
    // differential source selected in place of host but silent: one miss, lock lost
    wr(tss_pkg::REG_CTRL, 32'h00d, 2'h0);
    repeat (2500) @(posedge clk_sys_i);
    rd_chk(tss_pkg::REG_STATUS, 32'h0);
    chk1(synced, 1'b0);
    rd_chk(tss_pkg::REG_MISSED, 32'h1);
    wr(tss_pkg::REG_CTRL, 32'h20d, 2'h0);
    rd_chk(tss_pkg::REG_CTRL, 32'h1);
    chk1(out_oe, 1'b0);
    wr(tss_pkg::REG_CTRL, 32'h805, 2'h0);
    rd_chk(tss_pkg::REG_TOTAL, 32'h0);
    // a reload in mid-run loses the selectors; software writes them again
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_chk(tss_pkg::REG_CTRL, 32'h1);
    chk1(out_oe, 1'b0);
    wr(tss_pkg::REG_CTRL, 32'h009, 2'h0);
    rd_chk(tss_pkg::REG_CTRL, 32'h9);
    test_done();
  end

  // watchdog well beyond the expected run of about 3100 cycles
  // give up after bounded wait
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    errors++;
    test_done();
  end
endmodule
